// ---- hw/lsb_seq.sv ----
// Local memory bus sequencer: refresh, transfers, init, host handoff, APB registers
`timescale 1ns/10ps
module lsb_seq import lsb_pkg::*; (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              bus_request_n,
	input  wire logic              user_timing_strap,
	input  wire logic              external_interrupt_three,
	input  wire logic [2:0]        cycle_timing_code,
	output logic                   bus_grant_n,
	output logic      [1:0]        req_priority,
	output logic                   bus_oe_n,
	output logic      [ADDR_W-1:0] addr,
	output logic                   row_strobe_n,
	output logic                   transfer_column_strobe_n,
	output logic                   write_n,
	output logic      [5:0]        cycle_status
);
	lsb_pin_if pins ();
	lsb_pin_sync u_sync (
		.clk                      (clk),
		.rst_n                    (rst_n),
		.bus_request_n            (bus_request_n),
		.user_timing_strap        (user_timing_strap),
		.external_interrupt_three (external_interrupt_three),
		.cycle_timing_code        (cycle_timing_code),
		.pins                     (pins)
	);

	lsb_state_t        state;
	lsb_state_t        next_state;
	logic [2:0]        kind;
	logic [31:0]       row;
	logic [31:0]       tap;
	logic [2:0]        pend;
	logic              cmd_pend;
	logic              core_running;
	logic              fetch_pend;
	logic              fetching;
	logic              init_done;
	logic              sd_inited;
	logic [5:0]        ref_cnt;
	logic [15:0]       pseudo;
	logic [31:0]       mode_word;
	logic              int3_q;
	logic              sd_code;

	// APB decode: zero wait states, unmapped addresses answer with an error
	wire wr_en      = psel && penable && pwrite;
	wire hit_ctrl   = paddr == OFF_CTRL;
	wire hit_row    = paddr == OFF_ROW;
	wire hit_tap    = paddr == OFF_TAP;
	wire hit_pend   = paddr == OFF_PEND;
	wire hit_stat   = paddr == OFF_STAT;
	wire mapped     = hit_ctrl || hit_row || hit_tap || hit_pend || hit_stat;
	wire go_write   = wr_en && hit_ctrl && pwdata[CTRL_GO];
	// Fetch goes first; a command waits rather than being dropped beside it
	wire cmd_take   = state == ST_IDLE && init_done && cmd_pend && pins.bus_request_n &&
		!fetch_pend;
	wire is_write   = kind == KIND_WR || kind == KIND_SPL_WR;
	wire [31:0] stat_word = {20'h00000, pins.little_endian, core_running, sd_inited,
		init_done, cmd_pend, !bus_grant_n, 2'h0, state};

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = hit_ctrl ? {28'h0000000, kind, 1'b0} :
		hit_row ? row : hit_tap ? tap : hit_pend ? {29'h00000000, pend} :
		hit_stat ? stat_word : 32'h00000000;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			kind <= KIND_RD;
			row  <= 32'h00000000;
			tap  <= 32'h00000000;
			pend <= 3'h0;
		end else if (wr_en) begin
			if (hit_ctrl)
				kind <= pwdata[3:1];
			if (hit_row)
				row <= pwdata;
			if (hit_tap)
				tap <= pwdata;
			if (hit_pend)
				pend <= pwdata[2:0];
		end
	end

	// A new go in the cycle the engine takes the last one is kept
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cmd_pend <= 1'b0;
		else if (go_write)
			cmd_pend <= 1'b1;
		else if (cmd_take)
			cmd_pend <= 1'b0;
	end

	// Core start and deferred instruction fetch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			int3_q <= 1'b0;
		else
			int3_q <= pins.ext_int3;
	end
	wire int3_rise = pins.ext_int3 && !int3_q;
	wire fetch_take = state == ST_IDLE && init_done && fetch_pend && pins.bus_request_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			core_running <= 1'b0;
			fetch_pend   <= 1'b0;
		end else if (pins.straps_valid && !init_done && state == ST_REF_START &&
			ref_cnt == 6'h00) begin
			core_running <= pins.core_start;
			fetch_pend   <= pins.core_start;
		end else if (init_done && !core_running && int3_rise) begin
			core_running <= 1'b1;
			fetch_pend   <= 1'b1;
		end else if (fetch_take) begin
			fetch_pend <= 1'b0;
		end
	end

	assign sd_code   = !pins.cycle_timing_code[2];
	assign mode_word = lsb_mode_word(pins.cycle_timing_code);

	always_comb begin
		next_state = state;
		unique case (state)
			ST_REF_START: begin
				if (!pins.straps_valid)
					next_state = ST_REF_START;
				else if (sd_code && !sd_inited && !init_done)
					next_state = ST_PRE;
				else if (sd_code)
					next_state = ST_SD_REF;
				else
					next_state = ST_REF_CAS;
			end
			ST_PRE:        next_state = ST_MODE;
			ST_MODE:       next_state = ST_REF_START;
			ST_REF_CAS:    next_state = ST_REF_BOTH;
			ST_REF_BOTH:   next_state = ST_REF_END;
			ST_SD_REF:     next_state = ST_REF_END;
			ST_REF_END: begin
				if (!init_done && ref_cnt != 6'(INIT_REFRESH - 1))
					next_state = ST_REF_START;
				else
					next_state = ST_IDLE;
			end
			ST_IDLE: begin
				if (!pins.bus_request_n)
					next_state = ST_HAND_OFF;
				else if (fetch_pend)
					next_state = ST_ACT;
				else if (cmd_pend && kind == KIND_REF)
					next_state = ST_REF_START;
				else if (cmd_pend)
					next_state = ST_ACT;
			end
			ST_ACT:        next_state = ST_COL;
			ST_COL:        next_state = ST_CLOSE;
			ST_CLOSE:      next_state = ST_IDLE;
			ST_HAND_OFF:   next_state = ST_HAND_GRANT;
			ST_HAND_GRANT: next_state = pins.bus_request_n ? ST_HAND_BACK : ST_HAND_GRANT;
			ST_HAND_BACK:  next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			state <= ST_REF_START;
		else
			state <= next_state;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_cnt   <= 6'h00;
			init_done <= 1'b0;
			sd_inited <= 1'b0;
			pseudo    <= PSEUDO_INIT;
			fetching  <= 1'b0;
		end else begin
			if (state == ST_MODE)
				sd_inited <= 1'b1;
			if (state == ST_REF_END) begin
				pseudo <= pseudo - 16'h0001;
				if (!init_done)
					ref_cnt <= ref_cnt + 6'h01;
				if (!init_done && ref_cnt == 6'(INIT_REFRESH - 1))
					init_done <= 1'b1;
			end
			if (fetch_take)
				fetching <= 1'b1;
			else if (cmd_take)
				fetching <= 1'b0;
		end
	end

	// Strobe and address decode, registered below so all memory bus pins leave flops
	wire ras_low   = state == ST_ACT || state == ST_REF_BOTH || state == ST_SD_REF ||
		state == ST_PRE || state == ST_MODE || state == ST_CLOSE;
	wire cas_low   = state == ST_COL || state == ST_REF_CAS || state == ST_REF_BOTH ||
		state == ST_SD_REF || state == ST_MODE;
	wire wr_low    = (state == ST_COL && is_write && !fetching) || state == ST_PRE ||
		state == ST_MODE || state == ST_CLOSE;
	wire floating  = state == ST_HAND_OFF || state == ST_HAND_GRANT || state == ST_HAND_BACK;
	wire [31:0] next_addr =
		(state == ST_SD_REF) ? {pseudo, LOW_ZERO} :
		(state == ST_PRE) ? PRE_ALL_ADDR :
		(state == ST_MODE) ? mode_word :
		(state == ST_ACT && fetching) ? FETCH_BASE :
		(state == ST_COL && fetching) ? FETCH_BASE :
		(state == ST_ACT) ? row :
		(state == ST_COL) ? tap : 32'h00000000;
	wire [5:0] next_status =
		(state == ST_PRE) ? STAT_PRE :
		(state == ST_MODE) ? STAT_MODE :
		(state == ST_REF_CAS || state == ST_REF_BOTH || state == ST_SD_REF) ? STAT_REF :
		((state == ST_ACT || state == ST_COL || state == ST_CLOSE) && fetching) ? STAT_FETCH :
		(state == ST_ACT || state == ST_COL || state == ST_CLOSE) ?
			(STAT_XFER | {3'h0, kind}) : STAT_IDLE;
	wire [1:0] next_pri =
		(pend[PEND_URGENT] || (cmd_pend && kind != KIND_REF)) ? PRI_HIGH :
		(pend[PEND_CACHE] || pend[PEND_UPKT] || fetch_pend) ? PRI_MID : PRI_LOW;

	// Outputs float in reset; grant and priority stay driven
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_oe_n                 <= 1'b1;
			bus_grant_n              <= 1'b1;
			req_priority             <= PRI_LOW;
			addr                     <= 32'h00000000;
			row_strobe_n             <= 1'b1;
			transfer_column_strobe_n <= 1'b1;
			write_n                  <= 1'b1;
			cycle_status             <= STAT_IDLE;
		end else begin
			bus_oe_n                 <= floating;
			bus_grant_n              <= state != ST_HAND_GRANT;
			req_priority             <= next_pri;
			addr                     <= next_addr;
			row_strobe_n             <= !ras_low;
			transfer_column_strobe_n <= !cas_low;
			write_n                  <= !wr_low;
			cycle_status             <= next_status;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [6:0] refs_seen;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			refs_seen <= 7'h00;
		else if (state == ST_REF_END && !init_done)
			refs_seen <= refs_seen + 7'h01;
	end

	sequence s_sd_refresh;
		!row_strobe_n && !transfer_column_strobe_n && cycle_status == STAT_REF &&
			$past(state) == ST_SD_REF;
	endsequence
	sequence s_release;
		row_strobe_n && transfer_column_strobe_n;
	endsequence

	a_sd_ref_pulse: assert property (s_sd_refresh |=> s_release)
		else $error("sdram refresh strobes not one cycle");
	a_sd_ref_addr: assert property (s_sd_refresh |-> addr[15:0] == LOW_ZERO)
		else $error("refresh low address not zero");
	a_grant_float: assert property ($fell(bus_grant_n) |-> bus_oe_n && $past(bus_oe_n))
		else $error("grant before bus floated");
	a_held_float: assert property (!bus_grant_n |-> bus_oe_n)
		else $error("bus driven while granted");
	a_grant_back: assert property ($rose(bus_grant_n) |-> bus_oe_n ##1 !bus_oe_n)
		else $error("bus driven before grant release");
	a_init_count: assert property ($rose(init_done) |-> refs_seen == 7'(INIT_REFRESH))
		else $error("init refresh count wrong");
	a_init_first: assert property (!init_done |-> !$rose(cycle_status == STAT_FETCH))
		else $error("access before init refresh done");
	a_pre_mode: assert property (state == ST_PRE |=> state == ST_MODE ##1
		state == ST_REF_START)
		else $error("precharge not followed by mode set");
	a_tap_col: assert property ($past(state) == ST_COL && !fetching && $past(!fetching) |->
		addr == $past(tap))
		else $error("column address not tap point");
	a_pri_urgent: assert property ($past(pend[PEND_URGENT]) |-> req_priority == PRI_HIGH)
		else $error("urgent priority code wrong");
	a_halted_wait: assert property (init_done && !core_running && !int3_rise |=>
		!fetch_pend)
		else $error("fetch while core halted");
endmodule

// ---- hw/lsb_pkg.sv ----
// Constants, codes and register map of the local bus sequencer
// Overview of operation
// - Both normal and split transfers between array and serial buffer are supported.
// - Read transfers use read signalling; write transfers use write signalling.
// - Column-time address of a transfer is the serial buffer tap point.
// - SDRAM refresh is used when the sampled timing code starts with zero.
// - SDRAM refresh drives row and column strobes low together for one cycle.
// - SDRAM refresh drives pseudo-address on upper half, zeros on lower half.
// - Finish current access, float the bus, then pull the grant low.
// - Priority output shows highest pending request: 11, 10 or 00.
// - In reset all bus outputs float except clock, grant and priority.
// - In reset all registers and internal logic take default values.
// - At reset release the timing strap selects big (low) or little endian.
// - At reset release a low request starts the core, high leaves it halted.
// - After reset the floated signals are driven to their inactive levels.
// - Thirty-two refresh cycles run after reset before any other access.
// - SDRAM code during init refresh inserts precharge-all then mode set.
// - A running core gets its instruction block fetched after init refresh.
// - A halted core's fetch waits for the first external interrupt three rising after init refresh.
// - Timing code sampled at mode set picks burst length and latency.
package lsb_pkg;
	localparam int          ADDR_W       = 32;
	localparam int          INIT_REFRESH = 32;
	localparam logic [7:0]  OFF_CTRL     = 8'h00;
	localparam logic [7:0]  OFF_ROW      = 8'h04;
	localparam logic [7:0]  OFF_TAP      = 8'h08;
	localparam logic [7:0]  OFF_PEND     = 8'h0C;
	localparam logic [7:0]  OFF_STAT     = 8'h10;
	localparam int          CTRL_GO      = 0;
	localparam int          PEND_URGENT  = 0;
	localparam int          PEND_CACHE   = 1;
	localparam int          PEND_UPKT    = 2;
	localparam logic [2:0]  KIND_RD      = 3'h0;
	localparam logic [2:0]  KIND_SPL_RD  = 3'h1;
	localparam logic [2:0]  KIND_WR      = 3'h2;
	localparam logic [2:0]  KIND_SPL_WR  = 3'h3;
	localparam logic [2:0]  KIND_REF     = 3'h4;
	localparam logic [5:0]  STAT_IDLE    = 6'h00;
	localparam logic [5:0]  STAT_XFER    = 6'h08;
	localparam logic [5:0]  STAT_REF     = 6'h10;
	localparam logic [5:0]  STAT_FETCH   = 6'h18;
	localparam logic [5:0]  STAT_PRE     = 6'h20;
	localparam logic [5:0]  STAT_MODE    = 6'h28;
	localparam logic [1:0]  PRI_HIGH     = 2'h3;
	localparam logic [1:0]  PRI_MID      = 2'h2;
	localparam logic [1:0]  PRI_LOW      = 2'h0;
	localparam logic [31:0] FETCH_BASE   = 32'h0FFFFFC0;
	localparam logic [31:0] PRE_ALL_ADDR = 32'h00000400;
	localparam logic [15:0] PSEUDO_INIT  = 16'hFFFF;
	localparam logic [15:0] LOW_ZERO     = 16'h0000;
	typedef enum logic [3:0] {
		ST_REF_START, ST_REF_CAS, ST_REF_BOTH, ST_REF_END, ST_SD_REF, ST_PRE, ST_MODE,
		ST_IDLE, ST_ACT, ST_COL, ST_CLOSE, ST_HAND_OFF, ST_HAND_GRANT, ST_HAND_BACK
	} lsb_state_t;
	// Burst length in bit 3, read latency in bits 2:0
	function automatic logic [31:0] lsb_mode_word(input logic [2:0] code);
		logic [2:0] lat;
		lat = (code[1:0] == 2'h0) ? 3'h2 : (code[1:0] == 2'h1) ? 3'h3 : 3'h4;
		return {28'h0000000, code[1:0] == 2'h3, lat};
	endfunction
endpackage

// ---- hw/lsb_pin_if.sv ----
// Synchronised pin levels and reset straps between the pin stage and the sequencer
`timescale 1ns/10ps
interface lsb_pin_if;
	logic       bus_request_n;
	logic       ext_int3;
	logic [2:0] cycle_timing_code;
	logic       little_endian;
	logic       core_start;
	logic       straps_valid;
	modport src (output bus_request_n, ext_int3, cycle_timing_code, little_endian,
		core_start, straps_valid);
	modport dst (input bus_request_n, ext_int3, cycle_timing_code, little_endian,
		core_start, straps_valid);
endinterface

// ---- hw/lsb_pin_sync.sv ----
// Two-stage pin synchronisers and strap capture at reset release
`timescale 1ns/10ps
module lsb_pin_sync import lsb_pkg::*; (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       bus_request_n,
	input  wire logic       user_timing_strap,
	input  wire logic       external_interrupt_three,
	input  wire logic [2:0] cycle_timing_code,
	lsb_pin_if.src          pins
);
	localparam int N = 6;
	logic [N-1:0] raw;
	logic [N-1:0] meta;
	logic [N-1:0] sync;
	logic         captured;
	assign raw = {user_timing_strap, external_interrupt_three, bus_request_n, cycle_timing_code};
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_sync
			// Inactive-high reset so request and strap read idle until sampled
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta[i] <= 1'b1;
					sync[i] <= 1'b1;
				end else begin
					meta[i] <= raw[i];
					sync[i] <= meta[i];
				end
			end
		end
	endgenerate
	// Straps taken at the first fully synchronised sample after release
	logic [1:0] settle;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			settle             <= 2'h0;
			captured           <= 1'b0;
			pins.little_endian <= 1'b0;
			pins.core_start    <= 1'b0;
		end else if (!captured) begin
			settle <= settle + 2'h1;
			if (settle == 2'h2) begin
				captured           <= 1'b1;
				pins.little_endian <= sync[5];
				pins.core_start    <= !sync[3];
			end
		end
	end
	assign pins.straps_valid     = captured;
	assign pins.cycle_timing_code = sync[2:0];
	assign pins.bus_request_n    = sync[3];
	assign pins.ext_int3         = !sync[4];
endmodule

// ---- bench/lsb_far_model.sv ----
// Behavioural host and memory side facing the sequencer's bus pins
`timescale 1ns/10ps
module lsb_far_model import lsb_pkg::*; (
	input  wire logic       clk,
	input  wire logic       want_bus,
	input  wire logic [2:0] code_sel,
	input  wire logic [1:0] req_priority,
	input  wire logic [5:0] cycle_status,
	input  wire logic       transfer_column_strobe_n,
	output logic            bus_request_n,
	output logic      [2:0] cycle_timing_code,
	output logic            transfer_enable_n
);
	// Host yields as soon as urgent work shows
	wire logic hand_back = (req_priority == PRI_HIGH);
	// Memory transfer strobe rebuilt from the status code
	assign transfer_enable_n = !(cycle_status[5:3] == 3'h1 && !transfer_column_strobe_n);
	assign cycle_timing_code = code_sel;
	initial bus_request_n = 1'b1;
	always @(posedge clk) begin
		bus_request_n <= !(want_bus && !hand_back);
	end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the local bus sequencer
`timescale 1ns/10ps
module tb_top import lsb_pkg::*;;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        strap = 1'b1, int3 = 1'b0, want_bus = 1'b0, prev_oe, both;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, addr, row, tap;
	logic [2:0]  code_sel = 3'h3, cycle_timing_code;
	logic        pready, pslverr, bus_request_n, bus_grant_n, bus_oe_n, xfer_en_n;
	logic        row_strobe_n, transfer_column_strobe_n, write_n;
	logic [1:0]  req_priority;
	logic [5:0]  cycle_status;
	logic [63:0] exp_rd[$], exp_mem[$], rec;
	int          miscompares = 0, cmp_count = 0, refs = 0, n;
	logic        prev_ref = 1'b0;

	lsb_seq uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .bus_request_n, .user_timing_strap(strap), .external_interrupt_three(int3),
		.cycle_timing_code, .bus_grant_n, .req_priority, .bus_oe_n, .addr, .row_strobe_n,
		.transfer_column_strobe_n, .write_n, .cycle_status);
	lsb_far_model far (.clk, .want_bus, .code_sel, .req_priority, .cycle_status,
		.transfer_column_strobe_n, .bus_request_n, .cycle_timing_code,
		.transfer_enable_n(xfer_en_n));

	always #2 clk = ~clk;

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic end_test(input string s);
		$display("test %s finished", s);
	endtask

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic apb(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_rd.push_back(64'(e));
		apb(a, 32'h0, 1'b0);
	endtask

	function automatic logic [63:0] ev(input logic [5:0] s, input logic [2:0] st,
		input logic [31:0] a);
		return {23'h0, s, st, a};
	endfunction

	// Latency 2/3/4 in bits 2:0, burst of two in bit 3
	function automatic logic [31:0] mode_exp(input logic [2:0] c);
		logic [2:0] lat;
		lat = (c[1:0] == 2'h0) ? 3'h2 : (c[1:0] == 2'h1) ? 3'h3 : 3'h4;
		return {28'h0, c[1:0] == 2'h3, lat};
	endfunction

	task automatic wait_mem();
		for (int i = 0; i < 1000 && exp_mem.size() != 0; i++) @(posedge clk);
		check(exp_mem.size(), 0);
	endtask

	task automatic push_fetch();
		exp_mem.push_back(ev(STAT_FETCH, 3'b011, FETCH_BASE));
		exp_mem.push_back(ev(STAT_FETCH, 3'b101, FETCH_BASE));
	endtask

	task automatic do_reset(input logic s, input logic w, input logic [2:0] c);
		rst_n <= 1'b0;
		strap <= s;
		want_bus <= w;
		code_sel <= c;
		repeat (6) @(posedge clk);
		check({bus_oe_n, bus_grant_n, req_priority}, 4'hC);
		exp_mem.push_back(ev(STAT_PRE, 3'b010, PRE_ALL_ADDR));
		exp_mem.push_back(ev(STAT_MODE, 3'b000, mode_exp(c)));
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		check(bus_oe_n, 1'b0);
		repeat (3) @(posedge clk);
		want_bus <= 1'b0;
	endtask

	// Register reads and memory commands are matched against the notes in order
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite && exp_rd.size() != 0)
			check({pslverr, prdata}, exp_rd.pop_front());
		if (!rst_n) begin
			refs = 0;
			prev_ref = 1'b0;
		end else begin
			both = !row_strobe_n && !transfer_column_strobe_n && write_n;
			if (both && !code_sel[2]) begin
				check(addr[15:0], 16'h0);
				check(prev_ref, 1'b0);
			end
			if (both) refs++;
			prev_ref = both;
			rec = {23'h0, cycle_status, row_strobe_n, transfer_column_strobe_n, write_n,
				cycle_status == STAT_REF ? 32'h0 : addr};
			if ((!row_strobe_n && transfer_column_strobe_n && (write_n || cycle_status == STAT_PRE))
				|| (row_strobe_n && !transfer_column_strobe_n) || (!row_strobe_n && !transfer_column_strobe_n && !write_n)) begin
				check({bus_oe_n, bus_grant_n}, 2'b01);
				if (row_strobe_n && !transfer_column_strobe_n)
					check(xfer_en_n, cycle_status == STAT_REF || cycle_status == STAT_FETCH);
				if (cycle_status == STAT_FETCH && !row_strobe_n) check(refs, INIT_REFRESH);
				check(rec, exp_mem.size() != 0 ? exp_mem.pop_front() : 64'h0);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		print_verdict();
	end

	initial begin
		void'($urandom(68));
		do_reset(1'b1, 1'b1, 3'h3);
		push_fetch();
		wait_mem();
		rd(OFF_STAT, 33'h00F07);
		rd(8'h14, 33'h100000000);
		end_test("running start");
		for (int k = 0; k < 4; k++) begin
			row = $urandom;
			tap = $urandom;
			apb(OFF_ROW, row, 1'b1);
			apb(OFF_TAP, tap, 1'b1);
			exp_mem.push_back(ev(STAT_XFER | 6'(k), 3'b011, row));
			exp_mem.push_back(ev(STAT_XFER | 6'(k), {2'b10, !k[1]}, tap));
			apb(OFF_CTRL, {28'h0, 3'(k), 1'b1}, 1'b1);
			wait_mem();
		end
		end_test("transfers");
		n = refs;
		apb(OFF_CTRL, 32'h9, 1'b1);
		repeat (20) @(posedge clk);
		check(refs, n + 1);
		code_sel <= 3'h4;
		repeat (6) @(posedge clk);
		exp_mem.push_back(ev(STAT_REF, 3'b101, 32'h0));
		apb(OFF_CTRL, 32'h9, 1'b1);
		wait_mem();
		repeat (6) @(posedge clk);
		code_sel <= 3'h3;
		end_test("refresh");
		for (int v = 0; v < 8; v++) begin
			apb(OFF_PEND, 32'(v), 1'b1);
			repeat (3) @(posedge clk);
			check(req_priority, v[0] ? PRI_HIGH : (v[2:1] != 0) ? PRI_MID : PRI_LOW);
		end
		apb(OFF_PEND, 32'h0, 1'b1);
		end_test("priority");
		want_bus <= 1'b1;
		prev_oe = 1'b0;
		for (int i = 0; i < 40 && bus_grant_n !== 1'b0; i++) begin
			prev_oe = bus_oe_n;
			tick();
		end
		check({prev_oe, bus_oe_n, bus_grant_n}, 3'b110);
		exp_mem.push_back(ev(STAT_XFER, 3'b011, row));
		exp_mem.push_back(ev(STAT_XFER, 3'b101, tap));
		// Pending command raises urgent priority, so the host hands back
		apb(OFF_CTRL, 32'h1, 1'b1);
		for (int i = 0; i < 40 && bus_grant_n !== 1'b1; i++) tick();
		check({bus_oe_n, bus_grant_n}, 2'b11);
		@(posedge clk);
		want_bus <= 1'b0;
		#1;
		check(bus_oe_n, 1'b0);
		wait_mem();
		end_test("host handoff");
		do_reset(1'b0, 1'b0, 3'h1);
		wait_mem();
		repeat (400) @(posedge clk);
		check(refs, INIT_REFRESH);
		rd(OFF_ROW, 33'h0);
		rd(OFF_STAT, 33'h00307);
		push_fetch();
		@(posedge clk);
		int3 <= 1'b1;
		repeat (4) @(posedge clk);
		int3 <= 1'b0;
		wait_mem();
		end_test("halted start");
		print_verdict();
	end
endmodule
